/* logic/sgc_pkg.sv */
// Purpose: constants for the switch global control register bank
// Assumes: avalon-mm word addressing is done by byte address, one word per register
// Notes: register indices are multiplied by four to give byte addresses
package sgc_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] GC1_INDEX = 4'h3;
  localparam logic [ADDR_W-1:0] GC2_INDEX = 4'h4;
  localparam int unsigned AVL_ADDR_W = ADDR_W + 2;
  localparam logic [AVL_ADDR_W-1:0] GC1_ADDR = {GC1_INDEX, 2'b00};
  localparam logic [AVL_ADDR_W-1:0] GC2_ADDR = {GC2_INDEX, 2'b00};
  // global control one fields
  localparam int unsigned GC1_PASS_ALL_BIT = 7;
  localparam int unsigned GC1_RSVD_BIT = 6;
  localparam int unsigned GC1_TX_FC_BIT = 5;
  localparam int unsigned GC1_RX_FC_BIT = 4;
  localparam int unsigned GC1_LEN_CHECK_BIT = 3;
  localparam int unsigned GC1_AGING_BIT = 2;
  localparam int unsigned GC1_FAST_AGE_BIT = 1;
  localparam int unsigned GC1_AGGR_BACKOFF_BIT = 0;
  // global control two fields
  localparam int unsigned GC2_VLAN_DISCARD_BIT = 7;
  localparam int unsigned GC2_MCAST_STORM_DIS_BIT = 6;
  localparam int unsigned GC2_BP_MODE_BIT = 5;
  localparam int unsigned GC2_FAIR_MODE_BIT = 4;
  localparam int unsigned GC2_NO_EXC_COLL_BIT = 3;
  localparam int unsigned GC2_HUGE_PKT_BIT = 2;
  localparam int unsigned GC2_LEGAL_SIZE_BIT = 1;
  localparam int unsigned GC2_PRIO_RESERVE_BIT = 0;
  // reset values; strap bits are zero here and loaded after reset release
  localparam logic [7:0] GC1_RESET = 8'h30;
  localparam logic [7:0] GC2_RESET = 8'hf1;
  // frame policing figures; sizes in bytes, collision limit and buffer reserve as counts
  localparam logic [10:0] LEN_TYPE_LIMIT = 11'h5dc;
  localparam logic [10:0] SIZE_HUGE = 11'h77c;
  localparam logic [10:0] SIZE_RELAXED = 11'h600;
  localparam logic [10:0] SIZE_TAGGED = 11'h5f2;
  localparam logic [10:0] SIZE_UNTAGGED = 11'h5ee;
  localparam logic [4:0] EXC_COLL_LIMIT = 5'h10;
  localparam logic [5:0] PRIO_BUFFERS = 6'h30;
  // aging timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned FAST_AGE_US = 800;
  localparam int unsigned FAST_AGE_CYCLES = FAST_AGE_US * CLK_MHZ;
endpackage : sgc_pkg

/* logic/sgc_regs.sv */
// Purpose: two global control registers of a three-port switch, avalon-mm slave
// Assumes: 20 MHz mclk_in; straps are static pins, synchronised before use
// Notes: decoded controls drive the fabric, mac and phy logic outside this block
// Notes on behaviour
// [R1] pass-all bit forwards every frame, errored too, but only in sniffer mode
// [R2] transmit flow control bit cleared means no pause frame is ever generated
// [R3] receive flow control bit cleared means received pause frames are ignored
// [R4] length check drops frames with length field below 1500 not matching size
// [R5] aging runs only while aging enable is set; clearing it stops aging
// [R6] aging enable resets to the inverse of the aging strap pin level
// [R7] fast-age bit switches aging to the 800 us fast period
// [R8] aggressive back-off bit selects the non-standard half-duplex back-off
// [R9] mismatch discard set blocks all vlan crossing; cleared lets known unicast cross
// [R10] software keeps mismatch discard set while port mirroring is in use
// [R11] storm disable bit limits storm control to broadcast; cleared adds DA[40]
// [R12] back-pressure mode set is carrier-sense based, cleared is collision based
// [R13] fair mode may drop frames from the non-flow-controlling port
// [R14] fair mode cleared flow-controls the flow-controlling port instead
// [R15] excessive collision bit cleared drops after 16 collisions, set retries forever
// [R16] huge packet bit accepts up to 1916 bytes and overrides the size check
// [R17] size check cleared allows 1536 bytes; set allows 1522 tagged, 1518 untagged
// [R18] legal-size check bit resets to the level of the size strap pin
// [R19] priority reserve with multiple queues keeps 48 buffers for queues 3 to 1
// [R20] software leaves reserved bit 6 of global control one at zero
// [R21] control bits read back as written; strap bits may be overwritten
`timescale 1ns/1ps
module sgc_regs (
  input wire logic mclk_in, // system clock, 20 MHz
  input wire logic rst_n_in, // asynchronous reset, active low
  input wire logic [5:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data, low byte used
  input wire logic [3:0] avs_byteenable_in, // byte enables
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // high until the access is answered
  input wire logic aging_default_strap_pin_in, // aging strap, pulled down
  input wire logic size_check_strap_pin_in, // size strap
  input wire logic multi_queue_on_in, // multiple queue feature active
  input wire logic sniffer_mode_in, // sniffer mode active
  output logic pass_all_frames_out, // forward errored frames too
  output logic tx_pause_enable_out, // may generate pause frames
  output logic rx_pause_enable_out, // obeys received pause frames
  output logic length_check_out, // police length field
  output logic aging_enable_out, // aging runs
  output logic fast_age_out, // fast aging period selected
  output logic [14:0] age_period_cycles_out, // fast age period in cycles, 0 when normal
  output logic aggressive_backoff_out, // non-standard back-off
  output logic vlan_strict_out, // no vlan crossing at all
  output logic storm_include_mcast_out, // storm control also covers DA[40]
  output logic bp_carrier_sense_out, // carrier-sense back pressure
  output logic fair_mode_out, // drop from non-flow-controlling port
  output logic drop_on_excess_coll_out, // drop after collision limit
  output logic [4:0] excess_coll_limit_out, // collision count that drops
  output logic [10:0] max_size_tagged_out, // largest tagged frame accepted
  output logic [10:0] max_size_untagged_out, // largest untagged frame accepted
  output logic [5:0] prio_reserved_buffers_out // buffers held for queues 3 to 1
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {SGC_IDLE, SGC_ANSWER} sgc_bus_t;

  typedef struct packed {
    sgc_bus_t bus;
    logic [2:0] strap_loaded;
    logic [1:0] aging_sync;
    logic [1:0] size_sync;
    logic [7:0] gc1;
    logic [7:0] gc2;
    logic [31:0] rdata;
    logic waitreq;
    logic pass_all;
    logic tx_fc;
    logic rx_fc;
    logic len_check;
    logic aging;
    logic fast_age;
    logic [14:0] age_period;
    logic aggr;
    logic vlan_strict;
    logic storm_mcast;
    logic bp_cs;
    logic fair;
    logic drop_coll;
    logic [4:0] coll_limit;
    logic [10:0] max_tag;
    logic [10:0] max_untag;
    logic [5:0] prio_buf;
  } sgc_state_t;

  localparam sgc_state_t SGC_RESET_STATE = '{
    bus: SGC_IDLE,
    strap_loaded: 3'h0,
    aging_sync: 2'h0,
    size_sync: 2'h0,
    gc1: sgc_pkg::GC1_RESET,
    gc2: sgc_pkg::GC2_RESET,
    rdata: 32'h0000_0000,
    waitreq: 1'b1,
    pass_all: 1'b0,
    tx_fc: 1'b0,
    rx_fc: 1'b0,
    len_check: 1'b0,
    aging: 1'b0,
    fast_age: 1'b0,
    age_period: 15'h0000,
    aggr: 1'b0,
    vlan_strict: 1'b0,
    storm_mcast: 1'b0,
    bp_cs: 1'b0,
    fair: 1'b0,
    drop_coll: 1'b0,
    coll_limit: 5'h00,
    max_tag: 11'h000,
    max_untag: 11'h000,
    prio_buf: 6'h00
  };

  sgc_state_t state_reg;
  sgc_state_t state_next;

  // unmapped addresses read zero and ignore writes
  function automatic logic [1:0] sgc_decode(input logic [5:0] addr);
    sgc_decode = {addr == sgc_pkg::GC2_ADDR, addr == sgc_pkg::GC1_ADDR};
  endfunction : sgc_decode

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] hit;
    logic [7:0] wr;
    logic [7:0] g1;
    logic [7:0] g2;
    hit = sgc_decode(avs_address_in);
    wr = avs_writedata_in[7:0];
    g1 = state_reg.gc1;
    g2 = state_reg.gc2;
    state_next = state_reg;
    // straps pass two flops before use
    state_next.aging_sync = {state_reg.aging_sync[0], aging_default_strap_pin_in};
    state_next.size_sync = {state_reg.size_sync[0], size_check_strap_pin_in};
    state_next.strap_loaded = {state_reg.strap_loaded[1:0], 1'b1};
    // third edge after release: only now does the second sync flop hold the pin level
    if (state_reg.strap_loaded == 3'b011) begin
      state_next.gc1[sgc_pkg::GC1_AGING_BIT] = ~state_reg.aging_sync[1]; // R6
      state_next.gc2[sgc_pkg::GC2_LEGAL_SIZE_BIT] = state_reg.size_sync[1]; // R18
    end
    // one wait cycle: the access answers on the second edge it is held
    state_next.waitreq = 1'b1;
    unique case (state_reg.bus)
      SGC_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          state_next.bus = SGC_ANSWER;
          state_next.waitreq = 1'b0;
          state_next.rdata = 32'h0000_0000;
          if (avs_read_in) begin
            state_next.rdata[7:0] = (hit[0] ? state_reg.gc1 : 8'h00)
                                  | (hit[1] ? state_reg.gc2 : 8'h00); // R21
          end
        end
      end
      SGC_ANSWER: begin
        state_next.bus = SGC_IDLE;
        // the write lands on the edge where the master sees waitrequest low;
        // it wins over the strap load if both land together
        if (avs_write_in && avs_byteenable_in[0]) begin
          if (hit[0]) begin
            state_next.gc1 = wr; // R21
          end
          if (hit[1]) begin
            state_next.gc2 = wr; // R21
          end
        end
      end
      default: begin
        state_next.bus = SGC_IDLE;
      end
    endcase
    // decoded controls, one cycle behind the register bits
    state_next.pass_all = g1[sgc_pkg::GC1_PASS_ALL_BIT] & sniffer_mode_in; // R1
    state_next.tx_fc = g1[sgc_pkg::GC1_TX_FC_BIT]; // R2
    state_next.rx_fc = g1[sgc_pkg::GC1_RX_FC_BIT]; // R3
    state_next.len_check = g1[sgc_pkg::GC1_LEN_CHECK_BIT]; // R4
    state_next.aging = g1[sgc_pkg::GC1_AGING_BIT]; // R5
    state_next.fast_age = g1[sgc_pkg::GC1_AGING_BIT] & g1[sgc_pkg::GC1_FAST_AGE_BIT]; // R7
    state_next.age_period = state_next.fast_age ? 15'(sgc_pkg::FAST_AGE_CYCLES) : 15'h0000; // R7
    state_next.aggr = g1[sgc_pkg::GC1_AGGR_BACKOFF_BIT]; // R8
    state_next.vlan_strict = g2[sgc_pkg::GC2_VLAN_DISCARD_BIT]; // R9
    state_next.storm_mcast = ~g2[sgc_pkg::GC2_MCAST_STORM_DIS_BIT]; // R11
    state_next.bp_cs = g2[sgc_pkg::GC2_BP_MODE_BIT]; // R12
    state_next.fair = g2[sgc_pkg::GC2_FAIR_MODE_BIT]; // R13 R14
    state_next.drop_coll = ~g2[sgc_pkg::GC2_NO_EXC_COLL_BIT]; // R15
    state_next.coll_limit = sgc_pkg::EXC_COLL_LIMIT; // R15
    if (g2[sgc_pkg::GC2_HUGE_PKT_BIT]) begin
      state_next.max_tag = sgc_pkg::SIZE_HUGE; // R16
      state_next.max_untag = sgc_pkg::SIZE_HUGE; // R16
    end else if (g2[sgc_pkg::GC2_LEGAL_SIZE_BIT]) begin
      state_next.max_tag = sgc_pkg::SIZE_TAGGED; // R17
      state_next.max_untag = sgc_pkg::SIZE_UNTAGGED; // R17
    end else begin
      state_next.max_tag = sgc_pkg::SIZE_RELAXED; // R17
      state_next.max_untag = sgc_pkg::SIZE_RELAXED; // R17
    end
    // reserve only matters with several queues; otherwise no buffers are held back
    state_next.prio_buf = (g2[sgc_pkg::GC2_PRIO_RESERVE_BIT] && multi_queue_on_in) ?
                          sgc_pkg::PRIO_BUFFERS : 6'h00; // R19
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SGC_RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign avs_readdata_out = state_reg.rdata;
  assign avs_waitrequest_out = state_reg.waitreq;
  assign pass_all_frames_out = state_reg.pass_all;
  assign tx_pause_enable_out = state_reg.tx_fc;
  assign rx_pause_enable_out = state_reg.rx_fc;
  assign length_check_out = state_reg.len_check;
  assign aging_enable_out = state_reg.aging;
  assign fast_age_out = state_reg.fast_age;
  assign age_period_cycles_out = state_reg.age_period;
  assign aggressive_backoff_out = state_reg.aggr;
  assign vlan_strict_out = state_reg.vlan_strict;
  assign storm_include_mcast_out = state_reg.storm_mcast;
  assign bp_carrier_sense_out = state_reg.bp_cs;
  assign fair_mode_out = state_reg.fair;
  assign drop_on_excess_coll_out = state_reg.drop_coll;
  assign excess_coll_limit_out = state_reg.coll_limit;
  assign max_size_tagged_out = state_reg.max_tag;
  assign max_size_untagged_out = state_reg.max_untag;
  assign prio_reserved_buffers_out = state_reg.prio_buf;

endmodule : sgc_regs

/* tb/sgc_regs_chk.sv */
// Purpose: port checker for sgc_regs
// Assumes: one clock domain, reset active low
// Notes: bound into every sgc_regs instance
`timescale 1ns/1ps
module sgc_regs_chk (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic [5:0] avs_address_in, // address
  input wire logic avs_read_in, // read
  input wire logic avs_write_in, // write
  input wire logic [31:0] avs_writedata_in, // data
  input wire logic [3:0] avs_byteenable_in, // enables
  input wire logic avs_waitrequest_out, // wait
  input wire logic multi_queue_on_in, // queues on
  input wire logic sniffer_mode_in, // sniffer
  input wire logic pass_all_frames_out, // pass all
  input wire logic tx_pause_enable_out, // tx pause
  input wire logic fast_age_out, // fast age
  input wire logic [14:0] age_period_cycles_out, // age period
  input wire logic storm_include_mcast_out, // storm scope
  input wire logic drop_on_excess_coll_out, // coll drop
  input wire logic [4:0] excess_coll_limit_out, // coll limit
  input wire logic [10:0] max_size_tagged_out, // tagged max
  input wire logic [10:0] max_size_untagged_out, // untagged max
  input wire logic [5:0] prio_reserved_buffers_out // reserve
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////
  sequence taken_s; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence wr_s; avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]; endsequence
  sequence gc1_wr_s; wr_s ##0 avs_address_in == sgc_pkg::GC1_ADDR; endsequence
  sequence gc2_wr_s; wr_s ##0 avs_address_in == sgc_pkg::GC2_ADDR; endsequence
  ans_latency_a: assert property (taken_s |=> !avs_waitrequest_out) else $error("late answer");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer too long");
  tx_fc_write_a: assert property (gc1_wr_s |=> ##1
    tx_pause_enable_out == $past(avs_writedata_in[5], 2)) else $error("tx pause wrong");
  storm_write_a: assert property (gc2_wr_s |=> ##1
    storm_include_mcast_out == !$past(avs_writedata_in[6], 2)) else $error("storm scope wrong");
  pass_gate_a: assert property (!sniffer_mode_in |=> !pass_all_frames_out) else $error("pass all");
  prio_gate_a: assert property (prio_reserved_buffers_out != 6'h0 |->
    prio_reserved_buffers_out == 6'h30 && $past(multi_queue_on_in)) else $error("reserve");
  fast_age_a: assert property (fast_age_out |-> age_period_cycles_out == 15'h3e80)
    else $error("fast age period");
  size_pair_a: assert property (max_size_tagged_out == 11'h5f2 |->
    max_size_untagged_out == 11'h5ee) else $error("size pair");
  coll_limit_a: assert property (drop_on_excess_coll_out |-> excess_coll_limit_out == 5'h10)
    else $error("collision limit");
endmodule : sgc_regs_chk
bind sgc_regs sgc_regs_chk u_chk (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in,
  .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_waitrequest_out,
  .multi_queue_on_in, .sniffer_mode_in, .pass_all_frames_out, .tx_pause_enable_out,
  .fast_age_out, .age_period_cycles_out, .storm_include_mcast_out, .drop_on_excess_coll_out,
  .excess_coll_limit_out, .max_size_tagged_out, .max_size_untagged_out,
  .prio_reserved_buffers_out);

/* tb/sgc_regs_tb_top.sv */
// Purpose: self-checking bench for sgc_regs
// Assumes: 20 MHz clock, avalon-mm master task below
// Notes: model keeps both registers and predicts every decoded output
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module sgc_regs_tb_top;
  logic mclk_in, rst_n_in, avs_read_in, avs_write_in, ag, sz, mq, sn;
  logic [5:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd, seed, d;
  logic [3:0] avs_byteenable_in;
  logic avs_waitrequest_out;
  logic [7:0] m1, m2;
  logic [5:0] a;
  wire [59:0] outs;
  int miscompares, tests_run;
  sgc_regs DUT (.mclk_in, .rst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .aging_default_strap_pin_in(ag), .size_check_strap_pin_in(sz), .multi_queue_on_in(mq),
    .sniffer_mode_in(sn), .pass_all_frames_out(outs[59]), .tx_pause_enable_out(outs[58]),
    .rx_pause_enable_out(outs[57]), .length_check_out(outs[56]), .aging_enable_out(outs[55]),
    .fast_age_out(outs[54]), .age_period_cycles_out(outs[53:39]),
    .aggressive_backoff_out(outs[38]), .vlan_strict_out(outs[37]),
    .storm_include_mcast_out(outs[36]), .bp_carrier_sense_out(outs[35]),
    .fair_mode_out(outs[34]), .drop_on_excess_coll_out(outs[33]),
    .excess_coll_limit_out(outs[32:28]), .max_size_tagged_out(outs[27:17]),
    .max_size_untagged_out(outs[16:6]), .prio_reserved_buffers_out(outs[5:0]));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [59:0] exp_outs();
    logic [10:0] t, u;
    t = m2[2] ? sgc_pkg::SIZE_HUGE : m2[1] ? sgc_pkg::SIZE_TAGGED : sgc_pkg::SIZE_RELAXED;
    u = m2[2] ? sgc_pkg::SIZE_HUGE : m2[1] ? sgc_pkg::SIZE_UNTAGGED : sgc_pkg::SIZE_RELAXED;
    return {m1[7] & sn, m1[5:2], m1[2] & m1[1], (m1[2] & m1[1]) ? 15'h3e80 : 15'h0, m1[0],
      m2[7], ~m2[6], m2[5:4], ~m2[3], 5'h10, t, u, (m2[0] & mq) ? 6'h30 : 6'h0};
  endfunction : exp_outs
  task automatic stop_test();
    $display("compares %0d, miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // request is held until waitrequest is seen low, for at most 20 edges, so the slave's exact latency is never assumed
  task automatic bus(input logic wr, input logic [5:0] ad, input logic [31:0] wd,
    input logic [3:0] be);
    int n;
    @(posedge mclk_in);
    avs_read_in <= !wr;
    avs_write_in <= wr;
    avs_address_in <= ad;
    avs_writedata_in <= wd;
    avs_byteenable_in <= be;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      miscompares++;
      stop_test();
    end
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus
  task automatic check_all();
    bus(1'b0, sgc_pkg::GC1_ADDR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, m1})
    bus(1'b0, sgc_pkg::GC2_ADDR, 32'h0, 4'h0);
    `CHK(rd, {24'h0, m2})
    `CHK(outs, exp_outs())
  endtask : check_all
  ////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    {rst_n_in, avs_read_in, avs_write_in, ag, sz, mq, sn} = 7'h0;
    {avs_address_in, avs_writedata_in, avs_byteenable_in} = 42'h0;
    seed = 32'h2b861a79;
    // straps only move while reset is held, as real pins would
    for (int i = 0; i < 4; i++) begin
      rst_n_in <= 1'b0;
      ag <= i[0];
      sz <= i[1];
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge mclk_in);
      m1 = {5'h06, ~ag, 2'h0};
      m2 = {6'h3c, sz, 1'b1};
      check_all();
    end
    for (int i = 0; i < 48; i++) begin
      repeat (8) seed = lfsr(seed);
      a = (seed[9:8] == 2'h0) ? sgc_pkg::GC1_ADDR : (seed[9:8] == 2'h1) ? sgc_pkg::GC2_ADDR :
        {seed[8], 5'h14};
      d = seed;
      d[6] = d[6] & (a != sgc_pkg::GC1_ADDR);
      // no port mirroring runs here, so vlan discard may be cleared freely
      mq <= seed[20];
      sn <= seed[21];
      bus(1'b1, a, d, seed[19:16]);
      if (seed[16] && a == sgc_pkg::GC1_ADDR) m1 = d[7:0];
      if (seed[16] && a == sgc_pkg::GC2_ADDR) m2 = d[7:0];
      check_all();
      bus(1'b0, a, 32'h0, 4'h0);
      `CHK(rd[7:0], a == sgc_pkg::GC1_ADDR ? m1 : a == sgc_pkg::GC2_ADDR ? m2 : 8'h0)
    end
    stop_test();
  end
endmodule : sgc_regs_tb_top
